// *** dv/avr_chk.sv ***
// checker for avr_channel: range reaction properties on the ports
// assumes it is bound onto avr_channel, one ref_clk domain
module avr_chk
  import avr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic param_load,
  input wire logic signed [15:0] out_code,
  input wire logic signed [15:0] adc_code,
  input wire logic adc_outside,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] in_report,
  input wire logic group_error_indicator,
  input wire logic diag_entry,
  input wire logic diag_int,
  input wire logic proc_int,
  input wire logic param_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // overflow input saturates high and lights the indicator
  property p_ofl; clk_en && adc_code >= AVR_OFL_LO |=> in_report == AVR_SAT_HI && group_error_indicator; endproperty
  a_ofl: assert property (p_ofl) else $error("overflow input not saturated");
  // underflow in every range saturates low
  property p_ufl; clk_en && param_ok && !param_load && !adc_outside && adc_code < AVR_UND_LO_BIP
    |=> in_report == AVR_SAT_LO && group_error_indicator; endproperty
  a_ufl: assert property (p_ufl) else $error("underflow input not saturated");
  // flow codes give a zero signal
  property p_dac; clk_en && (out_code >= AVR_OFL_LO || out_code < AVR_UND_LO_BIP) |=> dac_code == 16'h0000; endproperty
  a_dac: assert property (p_dac) else $error("flow output not zeroed");
  // no valid set: zero out, fault report
  property p_nopar; clk_en && !param_ok && !param_load
    |=> dac_code == 16'h0000 && group_error_indicator && in_report == AVR_SAT_HI; endproperty
  a_nopar: assert property (p_nopar) else $error("missing parameters not handled");
  property p_dpulse; diag_int && clk_en |=> !diag_int; endproperty
  a_dpulse: assert property (p_dpulse) else $error("diagnostic interrupt too long");
  property p_dent; diag_int |-> diag_entry; endproperty
  a_dent: assert property (p_dent) else $error("interrupt without entry");
  property p_ind; diag_entry |-> group_error_indicator; endproperty
  a_ind: assert property (p_ind) else $error("entry without indicator");
  property p_ppulse; proc_int && clk_en |=> !proc_int; endproperty
  a_ppulse: assert property (p_ppulse) else $error("process interrupt too long");
  c_dint: cover property (diag_int);
  c_pint: cover property (proc_int);
  c_live: cover property (dac_code == 16'h8700);
endmodule // avr_chk

bind avr_channel avr_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .param_load(param_load),
  .out_code(out_code), .adc_code(adc_code), .adc_outside(adc_outside), .dac_code(dac_code), .in_report(in_report),
  .group_error_indicator(group_error_indicator), .diag_entry(diag_entry), .diag_int(diag_int),
  .proc_int(proc_int), .param_ok(param_ok));

// *** dv/avr_ctl_model.sv ***
// controller and sensor side model: holds output and measured codes
// assumes the bench calls put at the falling edge
module avr_ctl_model (
  output logic signed [15:0] out_code,
  output logic signed [15:0] adc_code
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    out_code = 16'sh0000;
    adc_code = 16'sh0000;
  end
  // present a new pair of process values
  task automatic put(input logic signed [15:0] o, input logic signed [15:0] a);
    out_code = o;
    adc_code = a;
  endtask
endmodule // avr_ctl_model

// *** dv/tb.sv ***
// self-checking bench for avr_channel
// assumes avr_pkg, avr_channel, the checker and the controller model
module tb
  import avr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {avr_range_t r; logic [15:0] o, a, d, i; logic g;} avr_row_t;
  // range, out code, adc code, expected dac, report, indicator
  localparam avr_row_t rows[11] = '{
    '{AVR_RNG_LIVE, 16'h6c00, 16'h0000, 16'h8700, 16'h0000, 1'h0}, '{AVR_RNG_LIVE, 16'h5100, 16'he500, 16'h6c00, 16'he500, 1'h0},
    '{AVR_RNG_LIVE, 16'he500, 16'h7eff, 16'h0000, 16'h7eff, 1'h0}, '{AVR_RNG_LIVE, 16'he4ff, 16'he4ff, 16'h0000, 16'h8000, 1'h1},
    '{AVR_RNG_LIVE, 16'h7f00, 16'h7f00, 16'h0000, 16'h7fff, 1'h1}, '{AVR_RNG_LIVE, 16'h6c01, 16'h6c01, 16'h8701, 16'h6c01, 1'h0},
    '{AVR_RNG_UNI, 16'h6c00, 16'hffff, 16'h6c00, 16'h8000, 1'h1}, '{AVR_RNG_UNI, 16'h7eff, 16'h0001, 16'h7eff, 16'h0001, 1'h0},
    '{AVR_RNG_UNI, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 1'h0}, '{AVR_RNG_BIP, 16'h9400, 16'h8100, 16'h9400, 16'h8100, 1'h0},
    '{AVR_RNG_BIP, 16'h80ff, 16'h80ff, 16'h0000, 16'h8000, 1'h1}};
  logic ref_clk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, param_load = 1'h0, param_fault = 1'h0, adc_outside = 1'h0;
  avr_param_t param_in = '0;
  logic signed [15:0] out_code, adc_code;
  logic [15:0] dac_code, in_report;
  logic group_error_indicator, diag_entry, diag_int, proc_int, param_ok;
  int fail_count = 0, checks_done = 0, cyc = 0, nd = 0, np = 0, n0 = 0;
  avr_channel u_avr_channel (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .param_load(param_load),
    .param_in(param_in), .param_fault(param_fault), .out_code(out_code), .adc_code(adc_code),
    .adc_outside(adc_outside), .dac_code(dac_code), .in_report(in_report), .diag_int(diag_int),
    .group_error_indicator(group_error_indicator), .diag_entry(diag_entry), .proc_int(proc_int), .param_ok(param_ok));
  avr_ctl_model u_avr_ctl_model (.out_code(out_code), .adc_code(adc_code));
  initial forever #50 ref_clk = ~ref_clk;
  // pulse counters and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    nd += diag_int;
    np += proc_int;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // offer a parameter set, return once it is active or rejected
  task automatic ld(input avr_range_t r, input logic [2:0] en, input logic [15:0] hi, input logic f);
    param_in = '{r, en[2], en[1], en[0], hi, 16'sh8000};
    param_fault = f;
    param_load = 1'h1;
    @(negedge ref_clk);
    param_load = 1'h0;
    @(negedge ref_clk);
  endtask
  task automatic go(input logic [15:0] o, input logic [15:0] a);
    u_avr_ctl_model.put(o, a);
    @(negedge ref_clk);
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    chk(group_error_indicator, 16'h0000);
    reset_n = 1'h1;
    @(negedge ref_clk);
    chk(in_report, AVR_SAT_HI);
    chk(group_error_indicator, 16'h0001);
    for (int k = 0; k < $size(rows); k++) begin
      ld(rows[k].r, 3'h6, 16'h7fff, 1'h0);
      go(rows[k].o, rows[k].a);
      chk(dac_code, rows[k].d);
      chk(in_report, rows[k].i);
      chk(group_error_indicator, rows[k].g);
    end
    ld(AVR_RNG_LIVE, 3'h4, 16'h7fff, 1'h0);
    go(16'h0000, 16'h7fff);
    chk(diag_entry, 16'h0000);
    chk(group_error_indicator, 16'h0001);
    n0 = nd;
    ld(AVR_RNG_LIVE, 3'h6, 16'h7fff, 1'h0);
    go(16'h0000, 16'h7fff);
    chk(diag_entry, 16'h0001);
    chk(16'(nd - n0), 16'h0001);
    go(16'h0000, 16'h0000);
    ld(AVR_RNG_LIVE, 3'h1, 16'h03e8, 1'h0);
    n0 = np;
    go(16'h0000, 16'h03e9);
    go(16'h0000, 16'h03e9);
    chk(in_report, 16'h03e9);
    chk(16'(np - n0), 16'h0001);
    ld(AVR_RNG_LIVE, 3'h6, 16'h7fff, 1'h1);
    go(16'h0000, 16'h0000);
    chk(param_ok, 16'h0001);
    chk(in_report, 16'h0000);
    chk(dac_code, 16'h0000);
    chk(group_error_indicator, 16'h0001);
    ld(AVR_RNG_LIVE, 3'h6, 16'h7fff, 1'h0);
    go(16'h0000, 16'h0000);
    chk(group_error_indicator, 16'h0000);
    adc_outside = 1'h1;
    go(16'h0000, 16'h0064);
    chk(in_report, AVR_SAT_HI);
    adc_outside = 1'h0;
    // reset in mid-run: everything clears, then the missing set raises the fault path
    reset_n = 1'h0;
    @(negedge ref_clk);
    chk(param_ok, 16'h0000);
    chk(in_report, 16'h0000);
    chk(group_error_indicator, 16'h0000);
    reset_n = 1'h1;
    @(negedge ref_clk);
    chk(group_error_indicator, 16'h0001);
    chk(diag_entry, 16'h0001);
    ld(AVR_RNG_LIVE, 3'h6, 16'h7fff, 1'h0);
    clk_en = 1'h0;
    go(16'h7f00, 16'h0000);
    chk(dac_code, AVR_LIVE_OFS);
    test_done();
  end
endmodule // tb

// *** hdl/avr_channel.sv ***
// one analog channel pair: output reaction and input reaction with flags
// assumes the controller side runs on ref_clk; parameter load and values are synchronous strobes
module avr_channel
  import avr_pkg::*;
(
  input wire logic ref_clk, // 10 MHz clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic param_load, // one-cycle strobe: new parameter set offered
  input avr_param_t param_in, // offered parameter set
  input wire logic param_fault, // offered set is faulty
  input wire logic signed [15:0] out_code, // code from the controller for the output
  input wire logic signed [15:0] adc_code, // measured input code
  input wire logic adc_outside, // measurement outside parameterized range
  output logic [15:0] dac_code, // code sent to the converter, live-zero offset applied in the live-zero range
  output logic [15:0] in_report, // input value reported to the controller
  output logic group_error_indicator, // group error indicator
  output logic diag_entry, // diagnostic entry present
  output logic diag_int, // one-cycle diagnostic interrupt
  output logic proc_int, // one-cycle process interrupt
  output logic param_ok // a valid parameter set is active
);

  avr_param_t par_q, par_d; // active parameter set
  logic ok_q, ok_d; // active set is valid
  logic fault_q, fault_d; // last offered set was faulty
  logic [15:0] dac_q, dac_d; // registered converter code
  logic [15:0] rep_q, rep_d; // registered input report
  avr_flags_t flg_q, flg_d; // registered flag levels
  logic dint_q, dint_d; // diagnostic interrupt pulse
  logic pint_q, pint_d; // process interrupt pulse
  avr_band_t out_band; // band of the output code
  avr_band_t in_band; // band of the input code
  logic bad_range; // range selection invalid
  logic out_bad; // output fault condition
  logic in_bad; // input fault condition
  logic lim_hit; // input beyond a limit
  logic diag_now; // diagnostic condition this cycle

  // output band decode
  avr_classify u_out_cls (
    .code(out_code),
    .range(par_q.range),
    .band(out_band)
  );

  // input band decode, same range as the channel
  avr_classify u_in_cls (
    .code(adc_code),
    .range(par_q.range),
    .band(in_band)
  );

  // true when the band forces substitution or zero
  function automatic logic is_flow(input avr_band_t b);
    is_flow = (b == AVR_BAND_OFL) || (b == AVR_BAND_UFL);
  endfunction

  // next-state logic for parameters
  always_comb begin
    par_d = par_q;
    ok_d = ok_q;
    fault_d = fault_q;
    if (param_load) begin
      fault_d = param_fault || (param_in.range == AVR_RNG_BAD);
      if (!fault_d) begin // only a correct set replaces the active one
        par_d = param_in;
        ok_d = 1'b1;
      end
    end
  end

  assign bad_range = (par_q.range == AVR_RNG_BAD);
  assign out_bad = !ok_q || fault_q || bad_range;
  // a rejected set leaves the good one measuring, so only a missing set, a bad range or adc_outside substitutes
  assign in_bad = !ok_q || bad_range || adc_outside;
  assign lim_hit = (adc_code > par_q.hi_limit) || (adc_code < par_q.lo_limit);

  // next-state logic for converter code, report and flags
  always_comb begin
    dac_d = AVR_CODE_ZERO;
    rep_d = adc_code;
    flg_d = '0;
    diag_now = 1'b0;
    // output side
    if (out_bad) begin
      dac_d = AVR_CODE_ZERO; // zero and flags on fault
      flg_d.ge = 1'b1;
      diag_now = 1'b1;
    end else if (is_flow(out_band)) begin
      dac_d = AVR_CODE_ZERO; // zero signal, no flags
    end else if (par_q.range == AVR_RNG_LIVE) begin
      // 0 -> 1 V, 27648 -> 5 V, -6912 -> 0 V
      dac_d = 16'(out_code + $signed(AVR_LIVE_OFS));
    end else begin
      dac_d = out_code; // pass unchanged
    end
    // input side
    if (in_bad) begin
      rep_d = AVR_SAT_HI;
      flg_d.ge = 1'b1;
      diag_now = 1'b1;
    end else if (in_band == AVR_BAND_OFL) begin
      rep_d = AVR_SAT_HI;
      flg_d.ge = 1'b1;
      if (par_q.grp_diag_en && par_q.meas_rng_en) begin
        diag_now = 1'b1;
      end
    end else if (in_band == AVR_BAND_UFL) begin
      rep_d = AVR_SAT_LO;
      flg_d.ge = 1'b1;
      if (par_q.grp_diag_en && par_q.meas_rng_en) begin
        diag_now = 1'b1;
      end
    end else begin
      rep_d = adc_code; // measured value unchanged
    end
    // rejected set reported: flags stand and the output is zeroed while the good set keeps measuring
    if (fault_q) begin
      flg_d.ge = 1'b1;
      diag_now = 1'b1;
    end
    flg_d.diag = diag_now;
    flg_d.proc = !in_bad && lim_hit && par_q.proc_int_en;
    dint_d = diag_now && !flg_q.diag; // interrupt on a new diagnostic
    pint_d = flg_d.proc && !flg_q.proc; // interrupt on a new violation
  end

  // registers, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      par_q <= '0;
      ok_q <= 1'b0;
      fault_q <= 1'b0;
      dac_q <= AVR_CODE_ZERO;
      rep_q <= AVR_CODE_ZERO;
      flg_q <= '0;
      dint_q <= 1'b0;
      pint_q <= 1'b0;
    end else if (clk_en) begin
      par_q <= par_d;
      ok_q <= ok_d;
      fault_q <= fault_d;
      dac_q <= dac_d;
      rep_q <= rep_d;
      flg_q <= flg_d; // indicator tracks conditions, clears with them
      dint_q <= dint_d;
      pint_q <= pint_d;
    end
  end

  assign dac_code = dac_q;
  assign in_report = rep_q;
  assign group_error_indicator = flg_q.ge;
  assign diag_entry = flg_q.diag;
  assign diag_int = dint_q;
  assign proc_int = pint_q;
  assign param_ok = ok_q;
endmodule // avr_channel

// *** hdl/avr_classify.sv ***
// range classifier: maps a signed code and range to its band
// assumes purely combinational use from the same clock domain
module avr_classify
  import avr_pkg::*;
(
  input wire logic signed [15:0] code, // process value
  input avr_range_t range, // range selection
  output avr_band_t band // band of the code
);
  // band decode per range
  always_comb begin
    band = AVR_BAND_NOM;
    if (code >= AVR_OFL_LO) begin // overflow in every range
      band = AVR_BAND_OFL;
    end else if (code >= AVR_OVR_LO) begin // overrange band
      band = AVR_BAND_OVR;
    end else if (code < AVR_CODE_ZERO) begin
      unique case (range)
        AVR_RNG_LIVE: band = (code >= AVR_UND_LO_LIVE) ? AVR_BAND_UND : AVR_BAND_UFL;
        AVR_RNG_UNI: band = AVR_BAND_UFL; // no undershoot band
        AVR_RNG_BIP: begin
          if (code >= AVR_NEG_FS) begin
            band = AVR_BAND_NOM;
          end else if (code >= AVR_UND_LO_BIP) begin
            band = AVR_BAND_UND;
          end else begin
            band = AVR_BAND_UFL;
          end
        end
        AVR_RNG_BAD: band = AVR_BAND_UFL; // caller treats as fault
      endcase
    end
  end
endmodule // avr_classify

// *** hdl/avr_pkg.sv ***
// package for the analog value range reaction block: range codes, bands, types
// assumes a single 10 MHz clock domain and signed 16-bit process codes
package avr_pkg;
  localparam int unsigned AVR_CODE_W = 16; // width of a process value
  localparam logic signed [15:0] AVR_NOM_HI = 16'sh6c00; // 27648, full scale
  localparam logic signed [15:0] AVR_OVR_LO = 16'sh6c01; // 27649, first overrange code
  localparam logic signed [15:0] AVR_OVR_HI = 16'sh7eff; // 32511, last overrange code
  localparam logic signed [15:0] AVR_OFL_LO = 16'sh7f00; // 32512, first overflow code
  localparam logic signed [15:0] AVR_UND_LO_LIVE = 16'she500; // -6912, last undershoot code in live-zero range
  localparam logic signed [15:0] AVR_UND_LO_BIP = 16'sh8100; // -32512, last undershoot code in bipolar range
  localparam logic signed [15:0] AVR_NEG_FS = 16'sh9400; // -27648, negative full scale
  localparam logic signed [15:0] AVR_CODE_ZERO = 16'sh0000; // zero code and zero signal
  localparam logic [15:0] AVR_SAT_HI = 16'h7fff; // overflow substitute code
  localparam logic [15:0] AVR_SAT_LO = 16'h8000; // underflow substitute code
  localparam logic [15:0] AVR_LIVE_OFS = 16'h1b00; // 6912, span below zero code in live zero
  localparam logic [2:0] AVR_CNT_ZERO = 3'h0; // reset value of flag state

  // output range selection
  typedef enum logic [1:0] {
    AVR_RNG_LIVE = 2'h0, // 1-5 V / 4-20 mA
    AVR_RNG_UNI = 2'h1, // 0-10 V / 0-20 mA
    AVR_RNG_BIP = 2'h3, // +-10 V / +-20 mA
    AVR_RNG_BAD = 2'h2 // no valid range
  } avr_range_t;

  // band of a code
  typedef enum logic [2:0] {
    AVR_BAND_NOM = 3'h0,
    AVR_BAND_OVR = 3'h1,
    AVR_BAND_OFL = 3'h3,
    AVR_BAND_UND = 3'h2,
    AVR_BAND_UFL = 3'h6
  } avr_band_t;

  // channel parameter set
  typedef struct packed {
    avr_range_t range; // output range
    logic grp_diag_en; // group diagnostics enable
    logic meas_rng_en; // measuring range diagnostics enable
    logic proc_int_en; // process interrupt enable
    logic signed [15:0] hi_limit; // high process limit
    logic signed [15:0] lo_limit; // low process limit
  } avr_param_t;

  // reaction of one channel
  typedef struct packed {
    logic ge; // group error contribution
    logic diag; // diagnostic condition
    logic proc; // process limit condition
  } avr_flags_t;
endpackage : avr_pkg
